// >>> rtl/bal_pkg.sv
// bal_pkg: opcodes, sizes, cycle counts and carrier structs of the byte alu
// assumes the core that uses the alu drives the request from its own clock
package bal_pkg;

    // opcode high nibble selects the operation group
    localparam logic [3:0] HI_INC = 4'h0;
    localparam logic [3:0] HI_DEC = 4'h1;
    localparam logic [3:0] HI_ADD = 4'h2;
    localparam logic [3:0] HI_SUM_WITH_CARRY = 4'h3;
    localparam logic [3:0] HI_OR = 4'h4;
    localparam logic [3:0] HI_AND = 4'h5;
    localparam logic [3:0] HI_XOR = 4'h6;
    localparam logic [3:0] HI_SUB = 4'h9;

    // opcode low nibble selects the operand form
    localparam logic [3:0] LO_DIR_A = 4'h2;
    localparam logic [3:0] LO_DIR_IMM = 4'h3;
    localparam logic [3:0] LO_IMM = 4'h4;
    localparam logic [3:0] LO_DIR = 4'h5;
    localparam logic [3:0] LO_IND0 = 4'h6;
    localparam logic [3:0] LO_IND1 = 4'h7;
    localparam int REG_BIT = 3;

    // single-form opcodes
    localparam logic [7:0] OP_ROT_R = 8'h03;
    localparam logic [7:0] OP_ROT_RC = 8'h13;
    localparam logic [7:0] OP_ROT_L = 8'h23;
    localparam logic [7:0] OP_ROT_LC = 8'h33;
    localparam logic [7:0] OP_QUOT = 8'h84;
    localparam logic [7:0] OP_INC_PTR = 8'hA3;
    localparam logic [7:0] OP_PROD = 8'hA4;
    localparam logic [7:0] OP_NIB_X = 8'hC4;
    localparam logic [7:0] OP_DEC_FIX = 8'hD4;
    localparam logic [7:0] OP_ZERO = 8'hE4;
    localparam logic [7:0] OP_INVERT = 8'hF4;

    // instruction sizes in bytes and lengths in cycles
    localparam logic [1:0] LEN1 = 2'h1;
    localparam logic [1:0] LEN2 = 2'h2;
    localparam logic [1:0] LEN3 = 2'h3;
    localparam logic [2:0] CYC1 = 3'h1;
    localparam logic [2:0] CYC2 = 3'h2;
    localparam logic [2:0] CYC4 = 3'h4;

    // decimal adjust constants
    localparam logic [3:0] NIB_MAX = 4'h9;
    localparam logic [7:0] FIX_LO = 8'h06;
    localparam logic [7:0] FIX_HI = 8'h60;

    // where the byte result is written back
    typedef enum logic [1:0] {
        WB_NONE = 2'b00,
        WB_REG = 2'b01,
        WB_MEM = 2'b10
    } bal_wb_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } bal_state_t;

    // one instruction with its operands already fetched
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] byte1;
        logic [7:0] byte2;
        logic [7:0] acc;
        logic [7:0] b;
        logic cy;
        logic ac;
        logic [7:0] r0;
        logic [7:0] r1;
        logic [7:0] rn_val;
        logic [7:0] mem_val;
        logic [15:0] ptr16;
        logic [15:0] pc;
    } bal_req_t;

    // new core state after the instruction
    typedef struct packed {
        logic known;
        logic [7:0] acc;
        logic [7:0] b;
        logic cy;
        logic ac;
        logic ov;
        logic [15:0] ptr16;
        bal_wb_t wb;
        logic [7:0] wb_addr;
        logic [7:0] wb_data;
        logic [1:0] len;
        logic [2:0] cycles;
        logic [15:0] rel_dest;
    } bal_res_t;

endpackage : bal_pkg

// >>> rtl/bal_alu.sv
// bal_alu: byte arithmetic and logic datapath with sizes and cycle counts
// assumes the core fetches operands from mem_addr in the request cycle
// Function
// - opcodes and results follow the standard 8-bit architecture exactly.
// - indirect forms address internal memory with R0 or R1 contents.
// - relative offset byte is a signed two's-complement displacement.
// - sum_into_acc adds in 1 cycle; reg/ind 1 byte, dir/imm 2.
// - sum_with_carry adds operand plus carry in 1 cycle, all forms.
// - direct sum_with_carry is 2 bytes, 1 cycle.
// - immediate sum_with_carry is 2 bytes, 1 cycle.
// - diff_with_borrow subtracts operand and carry, 1 cycle; reg 1 byte.
// - indirect diff_with_borrow uses indirect_ptr_reg, 1 byte, 1 cycle.
// - immediate diff_with_borrow is 2 bytes, 1 cycle.
// - bitwise_and_op into accumulator, 1 cycle, every operand form.
// - bitwise_and_op accumulator into direct byte, 2 bytes, 1 cycle.
// - bitwise_and_op immediate into direct byte, 3 bytes, 2 cycles.
// - bitwise_or_op 1 cycle; immediate into direct 3 bytes, 2 cycles.
// - bitwise_xor_op into accumulator 1 cycle; indirect form 1 byte.
// - bitwise_xor_op accumulator into direct byte, 2 bytes, 1 cycle.
// - bitwise_xor_op immediate into direct byte, 3 bytes, 2 cycles.
// - rot_left_carry rotates accumulator and carry left, 1 byte 1 cycle.
// - rot_right_carry rotates accumulator and carry right, 1 byte 1 cycle.
`timescale 1ns/10ps
`default_nettype none

module bal_alu
    import bal_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    // request
    input wire logic req_valid,
    output logic req_ready,
    input wire bal_req_t req,
    output logic [7:0] mem_addr,
    // answer
    output logic res_done,
    output bal_res_t res
);

    // opcode fields
    logic [3:0] hi;
    logic [3:0] lo;
    logic is_reg;

    // operands picked by form
    logic [7:0] src;
    logic [7:0] lhs;

    // arithmetic, all flat so every op settles in the request cycle
    logic [8:0] sum9;
    logic [4:0] sum_nib;
    logic [8:0] diff9;
    logic [4:0] diff_nib;
    logic cin;
    logic [15:0] prod;

    // decimal adjust stages
    logic [8:0] fix1;
    logic [8:0] fix2;
    logic fix_cy;

    // add_one and reduce_by_one operand
    logic [7:0] step_in;

    // result and sequencer; unknown opcodes still take one slot
    bal_res_t next_res;
    bal_state_t state;
    logic [2:0] cnt;
    logic take;

    assign hi = req.opcode[7:4];
    assign lo = req.opcode[3:0];
    assign is_reg = req.opcode[REG_BIT];

    // memory operand address, fetched by the core this same cycle
    always_comb begin
        if (lo == LO_IND0) begin
            mem_addr = req.r0;
        end else if (lo == LO_IND1) begin
            mem_addr = req.r1;
        end else begin
            mem_addr = req.byte1;
        end
    end

    // source operand by form
    always_comb begin
        if (is_reg) begin
            src = req.rn_val;
        end else if (lo == LO_IMM) begin
            src = req.byte1;
        end else if (lo == LO_DIR_A) begin
            src = req.acc;
        end else if (lo == LO_DIR_IMM) begin
            src = req.byte2;
        end else begin
            src = req.mem_val;
        end
    end

    // left operand: direct byte for direct-destination logic forms
    assign lhs = (lo == LO_DIR_A || lo == LO_DIR_IMM) ? req.mem_val : req.acc;

    // adder carry in is zero for add, the carry flag otherwise; subtractor takes the carry flag
    assign cin = (hi == HI_ADD) ? 1'b0 : req.cy;
    assign sum9 = {1'b0, req.acc} + {1'b0, src} + {8'h00, cin};
    assign sum_nib = {1'b0, req.acc[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
    assign diff9 = {1'b0, req.acc} - {1'b0, src} - {8'h00, req.cy};
    assign diff_nib = {1'b0, req.acc[3:0]} - {1'b0, src[3:0]} - {4'h0, req.cy};
    assign prod = req.acc * req.b;

    // decimal adjust: carry is only ever set, never cleared
    assign fix1 = {1'b0, req.acc}
        + ((req.acc[3:0] > NIB_MAX || req.ac) ? {1'b0, FIX_LO} : 9'h000);
    assign fix_cy = req.cy | fix1[8];
    assign fix2 = {1'b0, fix1[7:0]}
        + ((fix1[7:4] > NIB_MAX || fix_cy) ? {1'b0, FIX_HI} : 9'h000);

    // step operand: accumulator form uses the accumulator itself
    assign step_in = (lo == LO_IMM) ? req.acc : src;

    // result of one instruction
    always_comb begin
        next_res = '0;
        next_res.known = 1'b1;
        next_res.acc = req.acc;
        next_res.b = req.b;
        next_res.cy = req.cy;
        next_res.ac = req.ac;
        next_res.ptr16 = req.ptr16;
        next_res.wb = WB_NONE;
        next_res.wb_addr = mem_addr;
        next_res.len = LEN1;
        next_res.cycles = CYC1;
        next_res.rel_dest = req.pc + {{8{req.byte1[7]}}, req.byte1};
        unique case (req.opcode)
            OP_ROT_R: begin
                next_res.acc = {req.acc[0], req.acc[7:1]};
            end
            OP_ROT_L: begin
                next_res.acc = {req.acc[6:0], req.acc[7]};
            end
            OP_ROT_RC: begin
                next_res.acc = {req.cy, req.acc[7:1]};
                next_res.cy = req.acc[0];
            end
            OP_ROT_LC: begin
                next_res.acc = {req.acc[6:0], req.cy};
                next_res.cy = req.acc[7];
            end
            OP_INC_PTR: begin
                next_res.ptr16 = req.ptr16 + 16'h0001;
                next_res.cycles = CYC2;
            end
            OP_PROD: begin
                next_res.acc = prod[7:0];
                next_res.b = prod[15:8];
                next_res.cy = 1'b0;
                next_res.ov = |prod[15:8];
                next_res.cycles = CYC4;
            end
            OP_QUOT: begin
                // divide by zero leaves a and b untouched and flags overflow
                if (req.b != 8'h00) begin
                    next_res.acc = req.acc / req.b;
                    next_res.b = req.acc % req.b;
                end
                next_res.cy = 1'b0;
                next_res.ov = (req.b == 8'h00);
                next_res.cycles = CYC4;
            end
            OP_NIB_X: begin
                next_res.acc = {req.acc[3:0], req.acc[7:4]};
            end
            OP_DEC_FIX: begin
                next_res.acc = fix2[7:0];
                next_res.cy = fix_cy | fix2[8];
            end
            OP_ZERO: begin
                next_res.acc = 8'h00;
            end
            OP_INVERT: begin
                next_res.acc = ~req.acc;
            end
            default: begin
                // operand-form groups decoded by high nibble
                if (lo == LO_IMM || lo == LO_DIR) begin
                    next_res.len = LEN2;
                end
                unique case (hi)
                    HI_INC, HI_DEC: begin
                        if (lo < LO_IMM) begin
                            next_res.known = 1'b0;
                        end else begin
                            next_res.wb_data = (hi == HI_INC)
                                ? step_in + 8'h01 : step_in - 8'h01;
                            if (lo == LO_IMM) begin
                                next_res.acc = next_res.wb_data;
                                next_res.len = LEN1;
                            end else if (is_reg) begin
                                next_res.wb = WB_REG;
                                next_res.wb_addr = {5'h00, req.opcode[2:0]};
                            end else begin
                                next_res.wb = WB_MEM;
                            end
                        end
                    end
                    HI_ADD, HI_SUM_WITH_CARRY: begin
                        if (lo < LO_IMM) begin
                            next_res.known = 1'b0;
                        end else begin
                            next_res.acc = sum9[7:0];
                            next_res.cy = sum9[8];
                            next_res.ac = sum_nib[4];
                            next_res.ov = (req.acc[7] == src[7])
                                && (sum9[7] != req.acc[7]);
                        end
                    end
                    HI_SUB: begin
                        if (lo < LO_IMM) begin
                            next_res.known = 1'b0;
                        end else begin
                            next_res.acc = diff9[7:0];
                            next_res.cy = diff9[8];
                            next_res.ac = diff_nib[4];
                            next_res.ov = (req.acc[7] != src[7])
                                && (diff9[7] != req.acc[7]);
                        end
                    end
                    HI_OR, HI_AND, HI_XOR: begin
                        if (hi == HI_OR) begin
                            next_res.wb_data = lhs | src;
                        end else if (hi == HI_AND) begin
                            next_res.wb_data = lhs & src;
                        end else begin
                            next_res.wb_data = lhs ^ src;
                        end
                        if (lo == LO_DIR_A) begin
                            next_res.wb = WB_MEM;
                            next_res.len = LEN2;
                        end else if (lo == LO_DIR_IMM) begin
                            next_res.wb = WB_MEM;
                            next_res.len = LEN3;
                            next_res.cycles = CYC2;
                        end else if (lo >= LO_IMM) begin
                            next_res.acc = next_res.wb_data;
                        end else begin
                            next_res.known = 1'b0;
                        end
                    end
                    default: begin
                        // not an alu opcode: no state changes
                        next_res.known = 1'b0;
                    end
                endcase
            end
        endcase
        if (!next_res.known) begin
            next_res.wb = WB_NONE;
            next_res.acc = req.acc;
            next_res.len = LEN1;
            next_res.cycles = CYC1;
        end
    end

    // handshake: answer stands after the op's cycle count
    assign res_done = (state == ST_BUSY) && (cnt == CYC1);
    assign req_ready = (state == ST_IDLE) || res_done;
    assign take = req_valid && req_ready;

    // sequencer; clk_en low freezes the count so timing stays in cycles
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            cnt <= 3'h0;
        end else if (clk_en) begin
            if (take) begin
                state <= ST_BUSY;
                cnt <= next_res.cycles;
            end else if (res_done) begin
                state <= ST_IDLE;
                cnt <= 3'h0;
            end else if (state == ST_BUSY) begin
                cnt <= cnt - 3'h1;
            end
        end
    end

    // result held from acceptance until the next request is taken
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            res <= '0;
        end else if (clk_en && take) begin
            res <= next_res;
        end
    end

endmodule : bal_alu

`default_nettype wire

// >>> sim/bal_mem_model.sv
// bal_mem_model: internal data memory behind the alu operand port
// assumes the read answers within the request cycle
`timescale 1ns/10ps
`default_nettype none
module bal_mem_model (
    // operand read port
    input wire logic [7:0] mem_addr,
    output logic [7:0] mem_val
);
    // inverted address as content: a wrong address shows at once
    assign mem_val = ~mem_addr;
endmodule : bal_mem_model
`default_nettype wire

// >>> sim/bal_alu_props.sv
// bal_alu_props: port checks on the byte alu
// assumes one clock domain, bound to every bal_alu
`timescale 1ns/10ps
`default_nettype none
module bal_alu_props
    import bal_pkg::*;
(
    // clock and control
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    // request and answer
    input wire logic req_valid,
    input wire logic req_ready,
    input wire bal_req_t req,
    input wire logic [7:0] mem_addr,
    input wire logic res_done,
    input wire bal_res_t res
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    logic take;
    // request accepted at this edge
    assign take = clk_en && req_valid && req_ready;
    a_ind0_addr: assert property (req.opcode[3:0] == LO_IND0 |-> mem_addr == req.r0)
        else $error("r0 address wrong");
    a_ind1_addr: assert property (req.opcode[3:0] == LO_IND1 |-> mem_addr == req.r1)
        else $error("r1 address wrong");
    a_add_sum: assert property (take && req.opcode == 8'h29 |=>
        res.acc == $past(req.acc) + $past(req.rn_val) && res.len == LEN1)
        else $error("add result wrong");
    a_diff_with_borrow_diff: assert property (take && req.opcode == 8'h96 |=>
        res.acc == $past(req.acc) - $past(req.mem_val) - $past(req.cy))
        else $error("subtract result wrong");
    a_two_wait: assert property (take && req.opcode == 8'h63 |=> !res_done && !req_ready)
        else $error("two cycle op done early");
    a_two_done: assert property ((take && req.opcode == 8'h63) ##1 clk_en [*2] |->
        res_done && res.wb_data == ($past(req.mem_val, 2) ^ $past(req.byte2, 2)))
        else $error("two cycle op wrong");
    a_prod_busy: assert property (take && req.opcode == OP_PROD |=>
        (!req_ready && !res_done) [*3])
        else $error("multiply not busy");
    a_prod_done: assert property ((take && req.opcode == OP_PROD) ##1 clk_en [*4] |->
        res_done && res.cycles == CYC4)
        else $error("multiply not done");
    a_rot_carry: assert property (take && req.opcode == OP_ROT_LC |=>
        {res.cy, res.acc} == {$past(req.acc), $past(req.cy)})
        else $error("rotate through carry wrong");
    a_rel_dest: assert property (take |=> res.rel_dest ==
        $past(req.pc) + {{8{$past(req.byte1[7])}}, $past(req.byte1)})
        else $error("relative target wrong");
    a_res_hold: assert property (!take |=> $stable(res))
        else $error("result moved without request");
    c_prod: cover property (take && req.opcode == OP_PROD);
    c_two: cover property (take && req.opcode == 8'h63);
    c_diff_with_borrow: cover property (take && req.opcode == 8'h96);
endmodule : bal_alu_props
bind bal_alu bal_alu_props u_bal_alu_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .clk_en(clk_en), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .mem_addr(mem_addr), .res_done(res_done), .res(res));
`default_nettype wire

// >>> sim/tb_top.sv
// tb_top: directed scenarios for the byte alu
// assumes bal_alu_props is bound and memory holds inverted addresses
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import bal_pkg::*;
;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic req_valid = 1'b0;
    logic req_ready;
    logic res_done;
    logic [7:0] mem_addr;
    logic [7:0] mem_val;
    bal_req_t rq = '0;
    bal_req_t req_w;
    bal_res_t res;
    int miscompares = 0;
    int comparisons = 0;
    int tick = 0;
    always #5 clk_sys = ~clk_sys;
    // memory answer merged into the request
    always_comb begin
        req_w = rq;
        req_w.mem_val = mem_val;
    end
    bal_alu u_bal_alu (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
        .req_valid(req_valid), .req_ready(req_ready), .req(req_w),
        .mem_addr(mem_addr), .res_done(res_done), .res(res));
    bal_mem_model u_bal_mem_model (.mem_addr(mem_addr), .mem_val(mem_val));
    task automatic end_sim();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    // hang guard, tests need little more than a hundred cycles
    always @(posedge clk_sys) begin
        tick++;
        if (tick == 3000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    function automatic bal_req_t base(input logic [7:0] op);
        base = '{opcode: op, byte1: 8'h44, byte2: 8'h0f, acc: 8'hc3, b: 8'h5a,
            cy: 1'b1, r0: 8'h30, r1: 8'h31, rn_val: 8'h5a, ptr16: 16'h12ff,
            pc: 16'h0100, default: '0};
    endfunction : base
    // one request; frz edges of clk_en low after the take stretch it
    task automatic run(input bal_req_t q, input int n, input int frz);
        int k;
        @(posedge clk_sys);
        rq <= q;
        req_valid <= 1'b1;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        if (frz > 0) begin
            clk_en <= 1'b0;
            repeat (frz) @(posedge clk_sys);
            clk_en <= 1'b1;
        end
        #1;
        k = 1 + frz;
        while (res_done !== 1'b1 && k < 16) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        chk("latency", 16'(n + frz), 16'(k));
    endtask : run
    task automatic t_arith();
        bal_req_t q;
        logic [7:0] o;
        logic c;
        logic [2:0] f;
        logic [1:0] sz;
        int sg;
        int u;
        int nb;
        int sv;
        logic [3:0] gs [3] = '{HI_ADD, HI_SUM_WITH_CARRY, HI_SUB};
        logic [3:0] fs [4] = '{LO_IMM, LO_DIR, LO_IND0, 4'h9};
        foreach (gs[i]) begin
            foreach (fs[j]) begin
                q = base({gs[i], fs[j]});
                o = fs[j] == LO_IMM ? q.byte1 : fs[j] == LO_DIR ? ~q.byte1 : q.rn_val;
                o = fs[j] == LO_IND0 ? ~q.r0 : o; // memory holds inverted addresses
                c = gs[i] == HI_ADD ? 1'b0 : q.cy;
                sg = gs[i] == HI_SUB ? -1 : 1;
                // plain integer sums, so carries and signs come out independently
                u = int'(q.acc) + sg * (int'(o) + int'(c));
                nb = int'(q.acc[3:0]) + sg * (int'(o[3:0]) + int'(c));
                sv = int'($signed(q.acc)) + sg * (int'($signed(o)) + int'(c));
                f = {u > 255 || u < 0, nb > 15 || nb < 0, sv > 127 || sv < -128};
                sz = fs[j] inside {LO_IMM, LO_DIR} ? 2'h2 : 2'h1;
                run(q, 1, 0);
                chk("acc", 16'(u[7:0]), 16'(res.acc));
                chk("cy_ac_ov", 16'(f), 16'({res.cy, res.ac, res.ov}));
                chk("len", 16'(sz), 16'(res.len));
            end
        end
    endtask : t_arith
    task automatic t_logic();
        bal_req_t q;
        logic [7:0] x;
        logic [7:0] y;
        logic [7:0] r;
        logic [1:0] sz;
        logic dir;
        logic [3:0] gs [3] = '{HI_OR, HI_AND, HI_XOR};
        logic [3:0] fs [4] = '{LO_DIR_A, LO_DIR_IMM, LO_IMM, LO_IND1};
        foreach (gs[i]) begin
            foreach (fs[j]) begin
                q = base({gs[i], fs[j]});
                dir = fs[j] inside {LO_DIR_A, LO_DIR_IMM};
                x = fs[j] == LO_IMM ? q.byte1 : fs[j] == LO_IND1 ? ~q.r1 : ~q.byte1;
                y = fs[j] == LO_DIR_IMM ? q.byte2 : q.acc;
                r = gs[i] == HI_OR ? x | y : gs[i] == HI_AND ? x & y : x ^ y;
                sz = fs[j] == LO_DIR_IMM ? 2'h3 : fs[j] == LO_IND1 ? 2'h1 : 2'h2;
                run(q, fs[j] == LO_DIR_IMM ? 2 : 1, 0);
                chk("res", 16'(r), 16'(dir ? res.wb_data : res.acc));
                chk("wb", dir ? 16'(WB_MEM) : 16'(WB_NONE), 16'(res.wb));
                chk("len", 16'(sz), 16'(res.len));
                chk("cy", 16'(q.cy), 16'(res.cy));
            end
        end
    endtask : t_logic
    task automatic t_acc();
        bal_req_t q;
        logic [7:0] ops [10] = '{OP_ROT_R, OP_ROT_RC, OP_ROT_L, OP_ROT_LC, OP_ZERO,
            OP_INVERT, OP_NIB_X, OP_DEC_FIX, 8'h04, 8'h14};
        logic [8:0] ex [10] = '{9'h0da, 9'h15a, 9'h06b, 9'h16a, 9'h000,
            9'h04a, 9'h05b, 9'h115, 9'h0b6, 9'h0b4};
        foreach (ops[i]) begin
            q = base(ops[i]);
            q.acc = 8'hb5;
            q.cy = 1'b0;
            run(q, 1, 0);
            chk("acc_cy", 16'(ex[i]), 16'({res.cy, res.acc}));
            chk("len", 16'h0001, 16'(res.len));
        end
    endtask : t_acc
    task automatic t_misc();
        bal_req_t q;
        run(base(8'h0b), 1, 0);
        chk("inc_reg", 16'h035b, {res.wb_addr, res.wb_data});
        chk("inc_reg_wb", 16'(WB_REG), 16'(res.wb));
        run(base(8'h15), 1, 0);
        chk("dec_dir", 16'h44ba, {res.wb_addr, res.wb_data});
        chk("dec_dir_len", 16'h0002, 16'(res.len));
        run(base(OP_INC_PTR), 2, 0);
        chk("ptr", 16'h1300, res.ptr16);
        run(base(OP_PROD), 4, 0);
        chk("prod", 16'h448e, {res.b, res.acc});
        chk("prod_ov_cy", 16'h0002, 16'({res.ov, res.cy}));
        run(base(OP_QUOT), 4, 3);
        chk("quot", 16'h0f02, {res.b, res.acc});
        q = base(OP_QUOT);
        q.b = 8'h00;
        run(q, 4, 0);
        chk("quot_zero", 16'h00c3, {res.b, res.acc});
        chk("quot_zero_ov_cy", 16'h0002, 16'({res.ov, res.cy}));
        q = base(8'h00);
        q.byte1 = 8'hfe;
        run(q, 1, 0);
        chk("unknown", 16'h00c3, 16'({res.known, res.acc}));
        chk("rel_dest", 16'h00fe, res.rel_dest);
    endtask : t_misc
    // a second request waiting through the done cycle is taken back to back
    task automatic t_order();
        @(posedge clk_sys);
        rq <= base(8'h04);
        req_valid <= 1'b1;
        @(posedge clk_sys);
        rq <= base(8'h14);
        @(posedge clk_sys);
        req_valid <= 1'b0;
        #1;
        chk("b2b_dec", 16'h01c2, 16'({res_done, res.acc}));
    endtask : t_order
    initial begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1;
        chk("rst_ready", 16'h0001, 16'(req_ready));
        chk("rst_res", 16'h0000, 16'({res_done, res.acc}));
        t_arith();
        t_logic();
        t_acc();
        t_misc();
        t_order();
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
